// ===== hw/can_cfg_pkg.sv
// Purpose: Shared constants and types for the CAN configuration block.
// Assumes: 32-bit Avalon-MM word addressing in bytes, 16-bit registers.
// Notes:   Offsets, field positions, reset values and counts live here.
package can_cfg_pkg;

  // ***********************************************************
  // Register byte offsets
  // ***********************************************************
  localparam logic [5:0] OFF_FLAGS     = 6'h00;
  localparam logic [5:0] OFF_IRQ_EN    = 6'h04;
  localparam logic [5:0] OFF_ERR_CNT   = 6'h08;
  localparam logic [5:0] OFF_TIMING1   = 6'h0c;
  localparam logic [5:0] OFF_TIMING2   = 6'h10;
  localparam logic [5:0] OFF_FILT_EN   = 6'h14;
  localparam logic [5:0] OFF_ROUTE0    = 6'h18;
  localparam int         ROUTE_REGS    = 4;

  // ***********************************************************
  // Field positions and masks
  // ***********************************************************
  localparam logic [7:0] FLAG_MASK     = 8'hef;
  localparam int         TX_BUF_BIT    = 0;
  localparam int         RX_BUF_BIT    = 1;
  localparam int         WAKE_BIT      = 6;
  localparam logic [15:0] T1_MASK      = 16'h00ff;
  localparam logic [15:0] T2_MASK      = 16'h47ff;
  localparam logic [3:0] ROUTE_FIFO    = 4'hf;

  // ***********************************************************
  // Reset values
  // ***********************************************************
  localparam logic [7:0]  FLAGS_RST    = 8'h00;
  localparam logic [7:0]  IRQ_EN_RST   = 8'h00;
  localparam logic [15:0] ERR_CNT_RST  = 16'h0000;
  localparam logic [15:0] TIMING1_RST  = 16'h0000;
  localparam logic [15:0] TIMING2_RST  = 16'h0000;
  localparam logic [15:0] FILT_EN_RST  = 16'hffff;
  localparam logic [15:0] ROUTE_RST    = 16'h0000;

  // ***********************************************************
  // Timing
  // ***********************************************************
  localparam int         CLK_NS        = 50;
  localparam int         WAKE_FILT_NS  = 150;
  localparam int         WAKE_FILT_CYC = (WAKE_FILT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] PROC_TIME_TQ  = 4'h2;

  // Bit-timing settings as the timing engine sees them.
  typedef struct packed {
    logic [1:0] jump_width;
    logic [5:0] quantum_prescaler;
    logic       wake_line_filter_sel;
    logic [2:0] phase_two_len;
    logic       phase_two_free_sel;
    logic       triple_sample_sel;
    logic [2:0] phase_one_len;
    logic [2:0] propagation_len;
  } timing_cfg_type;

  typedef enum logic [1:0] {SEG_SYNC, SEG_PROP, SEG_PH1, SEG_PH2} seg_state_type;

endpackage

// ===== hw/can_timing_filter_irq_config.sv
// Purpose: CAN interrupt flags/enables, error counts, bit timing, filter routing.
// Assumes: Receive pin is asynchronous; all other inputs share core_clk_in.
// Notes:   Avalon-MM slave with one wait state on every access.
//
// Summary of operation
// - Receive-buffer event sets flag bit 1, transmit-buffer event flag bit 0.
// - Enables at bit 7 invalid message, bit 6 wake-up, bit 5 error.
// - Enables bit 3 FIFO almost full, 2 overflow, 1 rx, 0 tx; reset zero.
// - Read-only counts: transmit errors bits 15-8, receive errors bits 7-0.
// - Jump width is two-bit field bits 7-6 plus one quanta.
// - Quantum lasts two times (prescaler plus one) module clocks.
// - Wake-up detection uses the line filter only when select bit is one.
// - Phase segment 2 length is bits 10-8 plus one quanta.
// - Select one uses programmed phase 2; zero uses max(phase 1, processing).
// - Sampling bit one takes three samples at sample point, else one.
// - Phase segment 1 length is bits 5-3 plus one quanta.
// - Propagation segment length is bits 2-0 plus one quanta.
// - Sixteen filter enable bits, set after reset, gate acceptance.
// - Pointer 1111 routes to receive FIFO, 0000-1110 to buffers 0-14.
// - Four pointers per register, lowest filter in bits 3-0.
// - Writing zero clears a flag; writing one is ignored.
//
// Design decisions made here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/10ps
module can_timing_filter_irq_config
  import can_cfg_pkg::*;
(
  input  wire logic        core_clk_in,        // Module clock, 20 MHz.
  input  wire logic        resetn_in,          // Asynchronous reset, active low.
  input  wire logic [5:0]  avs_address_in,     // Byte address.
  input  wire logic        avs_read_in,        // Read request.
  input  wire logic        avs_write_in,       // Write request.
  input  wire logic [31:0] avs_writedata_in,   // Write data.
  input  wire logic [3:0]  avs_byteenable_in,  // Byte lanes.
  output logic [31:0]      avs_readdata_out,   // Read data.
  output logic             avs_waitrequest_out,// Stall.
  input  wire logic [7:0]  flag_set_in,        // Event pulses, flag layout.
  input  wire logic [7:0]  tx_error_count_in,  // Transmit error counter.
  input  wire logic [7:0]  rx_error_count_in,  // Receive error counter.
  input  wire logic        can_rx_in,          // Bus receive pin.
  input  wire logic        filter_hit_valid_in,// Match vector valid pulse.
  input  wire logic [15:0] filter_hit_in,      // Raw filter matches.
  output logic             irq_out,            // Interrupt request level.
  output logic             tq_tick_out,        // One pulse per quantum.
  output logic             bit_start_out,      // Pulse at bit start.
  output logic             sample_point_out,   // Pulse at sample point.
  output logic             sampled_bit_out,    // Bit value taken.
  output logic [2:0]       jump_width_tq_out,  // Jump width in quanta.
  output logic             accept_out,         // Accepted hit pulse.
  output logic [3:0]       accept_filter_out,  // Winning filter.
  output logic             dest_to_fifo_out,   // Route to receive FIFO.
  output logic [3:0]       dest_buffer_out     // Route pointer.
);

  // ***********************************************************
  // Registers
  // ***********************************************************
  logic [7:0]  flags_reg, flags_next;
  logic [7:0]  irq_en_reg;
  logic [15:0] err_cnt_reg;
  logic [15:0] timing1_reg, timing2_reg;
  logic [15:0] filt_en_reg;
  logic [15:0] route_reg [ROUTE_REGS];
  logic        ack_reg;
  logic [31:0] rdata_reg;
  logic [15:0] rdata_mux;

  // Address decode and write strobes.
  wire        access    = avs_read_in | avs_write_in;
  wire        wr_take   = avs_write_in & ack_reg;
  wire [15:0] be_mask   = {{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
  wire [15:0] wdata     = avs_writedata_in[15:0];
  wire        sel_flags = avs_address_in == OFF_FLAGS;
  wire        sel_irqen = avs_address_in == OFF_IRQ_EN;
  wire        sel_err   = avs_address_in == OFF_ERR_CNT;
  wire        sel_t1    = avs_address_in == OFF_TIMING1;
  wire        sel_t2    = avs_address_in == OFF_TIMING2;
  wire        sel_fen   = avs_address_in == OFF_FILT_EN;
  wire [5:0]  route_off = avs_address_in - OFF_ROUTE0;
  wire        sel_route = (avs_address_in >= OFF_ROUTE0) && (route_off[5:2] < 4'(ROUTE_REGS))
                          && (avs_address_in[1:0] == 2'b00);
  wire [1:0]  route_idx = route_off[3:2];

  // One wait state: the answer comes on the second edge of a request.
  assign avs_waitrequest_out = access & ~ack_reg;
  assign avs_readdata_out    = rdata_reg;

  // Read mux; unmapped addresses read as zero.
  always_comb begin
    rdata_mux = 16'h0000;
    if (sel_flags) rdata_mux = {8'h00, flags_reg};
    if (sel_irqen) rdata_mux = {8'h00, irq_en_reg};
    if (sel_err)   rdata_mux = err_cnt_reg;
    if (sel_t1)    rdata_mux = timing1_reg;
    if (sel_t2)    rdata_mux = timing2_reg;
    if (sel_fen)   rdata_mux = filt_en_reg;
    if (sel_route) rdata_mux = route_reg[route_idx];
  end

  // Bus handshake and read capture.
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg   <= access & ~ack_reg;
      rdata_reg <= {16'h0000, rdata_mux};
    end
  end

  // ***********************************************************
  // Interrupt flags and request
  // ***********************************************************
  logic wake_event;

  // Writing zero clears; a new event in the same cycle wins over the clear.
  always_comb begin
    logic [7:0] clr;
    logic [7:0] set;
    clr = (wr_take && sel_flags) ? (be_mask[7:0] & ~wdata[7:0]) : 8'h00;
    set = flag_set_in;
    set[WAKE_BIT] = flag_set_in[WAKE_BIT] | wake_event;
    flags_next = ((flags_reg & ~clr) | set) & FLAG_MASK;
  end

  // Enabled flags combine into one level request.
  assign irq_out = |(flags_reg & irq_en_reg);

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      flags_reg   <= FLAGS_RST;
      irq_en_reg  <= IRQ_EN_RST;
      err_cnt_reg <= ERR_CNT_RST;
    end else begin
      flags_reg   <= flags_next;
      err_cnt_reg <= {tx_error_count_in, rx_error_count_in};
      if (wr_take && sel_irqen) begin
        irq_en_reg <= ((irq_en_reg & ~be_mask[7:0]) | (wdata[7:0] & be_mask[7:0]))
                      & FLAG_MASK;
      end
    end
  end

  // ***********************************************************
  // Configuration registers
  // ***********************************************************
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      timing1_reg <= TIMING1_RST;
      timing2_reg <= TIMING2_RST;
      filt_en_reg <= FILT_EN_RST;
    end else if (wr_take) begin
      if (sel_t1) timing1_reg <= ((timing1_reg & ~be_mask) | (wdata & be_mask)) & T1_MASK;
      if (sel_t2) timing2_reg <= ((timing2_reg & ~be_mask) | (wdata & be_mask)) & T2_MASK;
      if (sel_fen) filt_en_reg <= (filt_en_reg & ~be_mask) | (wdata & be_mask);
    end
  end

  // One route register per group of four filters.
  genvar gi;
  generate
    for (gi = 0; gi < ROUTE_REGS; gi++) begin : g_route
      always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          route_reg[gi] <= ROUTE_RST;
        end else if (wr_take && sel_route && route_idx == 2'(gi)) begin
          route_reg[gi] <= (route_reg[gi] & ~be_mask) | (wdata & be_mask);
        end
      end
    end
  endgenerate

  timing_cfg_type cfg;
  assign cfg = {timing1_reg[7:0], timing2_reg[14], timing2_reg[10:0]};

  // ***********************************************************
  // Receive pin synchroniser and wake-up filter
  // ***********************************************************
  logic       rx_meta_reg, rx_sync_reg, rx_prev_reg;
  logic [2:0] rx_hist_reg;
  logic [1:0] filt_cnt_reg;
  logic       rx_filt_reg, wake_prev_reg;

  wire wake_line = cfg.wake_line_filter_sel ? rx_filt_reg : rx_sync_reg;
  assign wake_event = wake_prev_reg & ~wake_line;

  // Filter passes a level only after it holds for the filter time.
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rx_meta_reg   <= 1'b1;
      rx_sync_reg   <= 1'b1;
      rx_prev_reg   <= 1'b1;
      rx_hist_reg   <= 3'b111;
      filt_cnt_reg  <= 2'b00;
      rx_filt_reg   <= 1'b1;
      wake_prev_reg <= 1'b1;
    end else begin
      rx_meta_reg   <= can_rx_in;
      rx_sync_reg   <= rx_meta_reg;
      rx_prev_reg   <= rx_sync_reg;
      rx_hist_reg   <= {rx_hist_reg[1:0], rx_sync_reg};
      wake_prev_reg <= wake_line;
      if (rx_sync_reg == rx_filt_reg) begin
        filt_cnt_reg <= 2'b00;
      end else if (filt_cnt_reg == 2'(WAKE_FILT_CYC - 1)) begin
        filt_cnt_reg <= 2'b00;
        rx_filt_reg  <= rx_sync_reg;
      end else begin
        filt_cnt_reg <= filt_cnt_reg + 2'b01;
      end
    end
  end

  // ***********************************************************
  // Time quantum and bit segments
  // ***********************************************************
  logic [6:0]    pre_cnt_reg;
  seg_state_type seg_reg;
  logic [3:0]    seg_cnt_reg;
  logic [3:0]    ph1_ext_reg;
  logic [3:0]    prop_len, ph1_len, ph2_len, seg_len;

  wire [6:0] pre_max = {cfg.quantum_prescaler, 1'b1};
  wire       tq_tick = pre_cnt_reg >= pre_max;  // Recovers when the prescaler is lowered mid-count.
  wire       rx_edge = rx_prev_reg & ~rx_sync_reg;
  assign jump_width_tq_out = {1'b0, cfg.jump_width} + 3'h1;

  assign prop_len = {1'b0, cfg.propagation_len} + 4'h1;
  assign ph1_len  = {1'b0, cfg.phase_one_len} + 4'h1;
  assign ph2_len  = cfg.phase_two_free_sel ? ({1'b0, cfg.phase_two_len} + 4'h1)
                  : (ph1_len > PROC_TIME_TQ ? ph1_len : PROC_TIME_TQ);

  always_comb begin
    case (seg_reg)
      SEG_SYNC: seg_len = 4'h1;
      SEG_PROP: seg_len = prop_len;
      SEG_PH1:  seg_len = ph1_len + ph1_ext_reg;
      SEG_PH2:  seg_len = ph2_len;
      default:  seg_len = 4'h1;
    endcase
  end

  wire seg_done = tq_tick && (seg_cnt_reg + 4'h1 >= seg_len);
  assign tq_tick_out = tq_tick;

  // Resynchronisation: an edge in phase 1 stretches it, in phase 2 shortens it.
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pre_cnt_reg <= 7'h00;
      seg_reg     <= SEG_SYNC;
      seg_cnt_reg <= 4'h0;
      ph1_ext_reg <= 4'h0;
    end else begin
      pre_cnt_reg <= tq_tick ? 7'h00 : pre_cnt_reg + 7'h01;
      if (seg_done) begin
        seg_cnt_reg <= 4'h0;
        case (seg_reg)
          SEG_SYNC: seg_reg <= SEG_PROP;
          SEG_PROP: seg_reg <= SEG_PH1;
          SEG_PH1:  seg_reg <= SEG_PH2;
          SEG_PH2:  seg_reg <= SEG_SYNC;
          default:  seg_reg <= SEG_SYNC;
        endcase
        if (seg_reg == SEG_PH1) ph1_ext_reg <= 4'h0;
      end else begin
        if (tq_tick) seg_cnt_reg <= seg_cnt_reg + 4'h1;
        if (rx_edge && seg_reg == SEG_PH1 && ph1_ext_reg == 4'h0)
          ph1_ext_reg <= {1'b0, jump_width_tq_out};
        if (rx_edge && seg_reg == SEG_PH2)
          seg_cnt_reg <= seg_cnt_reg + {1'b0, jump_width_tq_out};
      end
    end
  end

  // ***********************************************************
  // Sample point
  // ***********************************************************
  wire major = (rx_hist_reg[0] & rx_hist_reg[1]) | (rx_hist_reg[0] & rx_hist_reg[2])
             | (rx_hist_reg[1] & rx_hist_reg[2]);
  wire at_sample = seg_done && seg_reg == SEG_PH1;

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sample_point_out <= 1'b0;
      bit_start_out    <= 1'b0;
      sampled_bit_out  <= 1'b1;
    end else begin
      sample_point_out <= at_sample;
      bit_start_out    <= seg_done && seg_reg == SEG_PH2;
      if (at_sample)
        sampled_bit_out <= cfg.triple_sample_sel ? major : rx_hist_reg[0];
    end
  end

  // ***********************************************************
  // Filter acceptance and routing
  // ***********************************************************
  logic [3:0]  ptr [16];
  wire  [15:0] live_hits = filter_hit_in & filt_en_reg;

  generate
    for (gi = 0; gi < 16; gi++) begin : g_ptr
      assign ptr[gi] = route_reg[gi / 4][(gi % 4) * 4 +: 4];
    end
  endgenerate

  logic [3:0] win_idx;

  // Lowest numbered enabled filter wins.
  always_comb begin
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (live_hits[i]) idx = 4'(i);
    end
    win_idx = idx;
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      accept_out        <= 1'b0;
      accept_filter_out <= 4'h0;
      dest_to_fifo_out  <= 1'b0;
      dest_buffer_out   <= 4'h0;
    end else begin
      accept_out <= filter_hit_valid_in && (live_hits != 16'h0000);
      if (filter_hit_valid_in && live_hits != 16'h0000) begin
        accept_filter_out <= win_idx;
        dest_buffer_out   <= ptr[win_idx];
        dest_to_fifo_out  <= ptr[win_idx] == ROUTE_FIFO;
      end
    end
  end

  // ***********************************************************
  // Checks
  // ***********************************************************
  property p_flag_set;
    @(posedge core_clk_in) disable iff (!resetn_in)
    flag_set_in[RX_BUF_BIT] |=> flags_reg[RX_BUF_BIT];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("rx flag not set");

  property p_one_ignored;
    @(posedge core_clk_in) disable iff (!resetn_in)
    wr_take && sel_flags && !flags_reg[TX_BUF_BIT] && !flag_set_in[TX_BUF_BIT]
    |=> !flags_reg[TX_BUF_BIT];
  endproperty
  a_one_ignored: assert property (p_one_ignored) else $error("flag set by write");

  property p_irq;
    @(posedge core_clk_in) disable iff (!resetn_in)
    flag_set_in[TX_BUF_BIT] && irq_en_reg[TX_BUF_BIT] && !(wr_take && sel_irqen)
    |=> irq_out;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not raised");

  property p_err;
    @(posedge core_clk_in) disable iff (!resetn_in)
    1'b1 |=> err_cnt_reg == {$past(tx_error_count_in), $past(rx_error_count_in)};
  endproperty
  a_err: assert property (p_err) else $error("error count stale");

  property p_tq_min;
    @(posedge core_clk_in) disable iff (!resetn_in)
    tq_tick && cfg.quantum_prescaler == 6'h00 && !wr_take
    |=> !tq_tick ##1 (tq_tick || $past(wr_take));
  endproperty
  a_tq_min: assert property (p_tq_min) else $error("quantum not two clocks");

  property p_sample_ph1;
    @(posedge core_clk_in) disable iff (!resetn_in)
    at_sample |=> sample_point_out && seg_reg == SEG_PH2;
  endproperty
  a_sample_ph1: assert property (p_sample_ph1) else $error("sample not at phase 1 end");

  property p_accept_en;
    @(posedge core_clk_in) disable iff (!resetn_in)
    accept_out |-> $past(filter_hit_valid_in && live_hits[win_idx])
                   && accept_filter_out == $past(win_idx);
  endproperty
  a_accept_en: assert property (p_accept_en) else $error("disabled filter hit");

  property p_route;
    @(posedge core_clk_in) disable iff (!resetn_in)
    accept_out |-> dest_to_fifo_out == (dest_buffer_out == ROUTE_FIFO);
  endproperty
  a_route: assert property (p_route) else $error("route mismatch");

  property p_ph2_auto;
    @(posedge core_clk_in) disable iff (!resetn_in)
    !cfg.phase_two_free_sel |-> ph2_len >= ph1_len && ph2_len >= PROC_TIME_TQ;
  endproperty
  a_ph2_auto: assert property (p_ph2_auto) else $error("phase 2 too short");

endmodule

// ===== tb/can_bus_node_model.sv
// Purpose: Far CAN node that pulls the bus dominant when told to.
// Assumes: Recessive idle level is one, as seen behind the transceiver.
// Notes:   One go pulse holds the line dominant for dom_len_in clocks.
`timescale 1ns/10ps
module can_bus_node_model (
  input  wire logic       core_clk_in, // Bench clock.
  input  wire logic       go_in,       // Start a dominant pulse.
  input  wire logic [7:0] dom_len_in,  // Pulse length in clocks.
  output logic            can_rx_out   // Bus level seen by the block.
);
  logic [7:0] left_reg = 8'h00;
  // The line falls back to recessive between pulses, so no stale level lingers.
  always @(posedge core_clk_in) begin
    if (go_in) begin
      left_reg <= dom_len_in;
    end else if (left_reg != 8'h00) begin
      left_reg <= left_reg - 8'h01;
    end
  end
  assign can_rx_out = (left_reg == 8'h00);
endmodule

// ===== tb/test_can_timing_filter_irq_config.sv
// Purpose: Self-checking bench for the CAN configuration block.
// Assumes: Every bus access finishes well inside the cycle ceiling.
// Notes:   Reads and accepts are queued; a monitor checks them as they appear.
`timescale 1ns/10ps
module test_can_timing_filter_irq_config;
  import can_cfg_pkg::*;
  logic        core_clk_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic [5:0]  addr = 6'h00;
  logic        rd_en = 1'b0;
  logic        wr_en = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [7:0]  flag_set = 8'h00;
  logic [7:0]  tx_cnt, rx_cnt;
  logic        hit_valid = 1'b0;
  logic [15:0] hit_vec = 16'h0000;
  logic        go = 1'b0;
  logic [7:0]  dom_len = 8'h00;
  logic        can_rx, irq, tq, bs, sp, sb, acc, to_fifo, waitreq;
  logic [31:0] rdata;
  logic [2:0]  jw;
  logic [3:0]  acc_f, dest;
  logic [15:0] h;
  logic [31:0] rd_q[$];
  logic [8:0]  acc_q[$];
  logic [31:0] seed = 32'd9069;
  int          num_errors = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          n;
  localparam logic [5:0]  OFFS[8] = '{OFF_IRQ_EN, OFF_TIMING1, OFF_TIMING2, OFF_FILT_EN,
                                      6'h18, 6'h1c, 6'h20, 6'h24};
  localparam logic [15:0] RSTS[8] = '{0, 0, 0, 16'hffff, 0, 0, 0, 0};
  localparam logic [15:0] MSKS[8] = '{16'h00ef, 16'h00ff, 16'h47ff, 16'hffff,
                                      16'hffff, 16'hffff, 16'hffff, 16'hffff};
  localparam logic [15:0] T2V[4]  = '{16'h0288, 16'h0010, 16'h06d9, 16'h0000};
  localparam int          T2C[4]  = '{14, 16, 28, 10};

  always #25 core_clk_in = ~core_clk_in;

  can_bus_node_model far_node (.core_clk_in(core_clk_in), .go_in(go), .dom_len_in(dom_len),
                               .can_rx_out(can_rx));

  can_timing_filter_irq_config DUT (
    .core_clk_in(core_clk_in), .resetn_in(resetn_in), .avs_address_in(addr),
    .avs_read_in(rd_en), .avs_write_in(wr_en), .avs_writedata_in(wdata),
    .avs_byteenable_in(4'hf), .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
    .flag_set_in(flag_set), .tx_error_count_in(tx_cnt), .rx_error_count_in(rx_cnt),
    .can_rx_in(can_rx), .filter_hit_valid_in(hit_valid), .filter_hit_in(hit_vec),
    .irq_out(irq), .tq_tick_out(tq), .bit_start_out(bs), .sample_point_out(sp),
    .sampled_bit_out(sb), .jump_width_tq_out(jw), .accept_out(acc),
    .accept_filter_out(acc_f), .dest_to_fifo_out(to_fifo), .dest_buffer_out(dest));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic sel(input int k);
    return (k == 0) ? tq : (k == 1) ? bs : sp;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      $display("unexpected %s expected %h seen %h", what, exp, seen);
      num_errors++;
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Request is held until the edge that samples waitrequest low, then released.
  task automatic bus(input logic wr, input logic [5:0] a, input logic [15:0] d);
    @(posedge core_clk_in);
    addr <= a;
    wr_en <= wr;
    rd_en <= ~wr;
    wdata <= {16'h0000, d};
    do @(posedge core_clk_in); while (waitreq !== 1'b0);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] exp);
    rd_q.push_back(exp);
    bus(1'b0, a, 16'h0000);
  endtask

  task automatic pulse(input logic [7:0] f, input logic [15:0] hv, input logic [7:0] d);
    @(posedge core_clk_in);
    flag_set <= f;
    hit_valid <= (hv != 16'h0000);
    hit_vec <= hv;
    go <= (d != 8'h00);
    dom_len <= d;
    @(posedge core_clk_in);
    flag_set <= 8'h00;
    hit_valid <= 1'b0;
    go <= 1'b0;
  endtask

  // The second interval is kept, since a settings change may cut the first short.
  task automatic span(input int a, input int b, output int cnt);
    repeat (2) begin
      cnt = 0;
      do @(negedge core_clk_in); while (sel(a) !== 1'b1);
      do begin
        @(negedge core_clk_in);
        cnt++;
      end while (sel(b) !== 1'b1 && cnt < 400);
    end
  endtask

  // Monitor: every completed read and every accept pulse consumes the oldest note.
  always @(negedge core_clk_in) begin
    cycles++;
    if (cycles > 6000) begin
      num_errors++;
      test_done();
    end
    if (rd_en && waitreq === 1'b0) check(rdata, rd_q.pop_front(), "readdata");
    if (acc === 1'b1) check({acc_f, to_fifo, dest}, acc_q.pop_front(), "route");
  end

  initial begin
    tx_cnt <= 8'(rnd());
    rx_cnt <= 8'(rnd());
    repeat (10) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    for (int i = 0; i < 8; i++) rd(OFFS[i], RSTS[i]);
    rd(OFF_FLAGS, 32'h0);
    rd(6'h28, 32'h0);
    bus(1'b1, OFF_ERR_CNT, 16'(rnd()));
    rd(OFF_ERR_CNT, {16'h0000, tx_cnt, rx_cnt});
    for (int i = 0; i < 8; i++) begin
      h = 16'(rnd());
      bus(1'b1, OFFS[i], h);
      rd(OFFS[i], h & MSKS[i]);
    end
    $display("test registers done");
    bus(1'b1, OFF_IRQ_EN, 16'h0000);
    pulse(8'hff, 16'h0, 8'h00);
    rd(OFF_FLAGS, 32'h00ef);
    bus(1'b1, OFF_FLAGS, 16'h00fd);
    rd(OFF_FLAGS, 32'h00ed);
    bus(1'b1, OFF_FLAGS, 16'h00ff);
    rd(OFF_FLAGS, 32'h00ed);
    for (int b = 0; b < 8; b++) begin
      if (b == 4) continue;
      bus(1'b1, OFF_FLAGS, 16'h0000);
      bus(1'b1, OFF_IRQ_EN, 16'h00ef & ~(16'h1 << b));
      pulse(8'h01 << b, 16'h0, 8'h00);
      @(negedge core_clk_in) check(irq, 1'b0, "irq masked");
      bus(1'b1, OFF_IRQ_EN, 16'h1 << b);
      @(negedge core_clk_in) check(irq, 1'b1, "irq raised");
    end
    bus(1'b1, OFF_FLAGS, 16'h0000);
    @(negedge core_clk_in) check(irq, 1'b0, "irq cleared");
    $display("test interrupts done");
    bus(1'b1, OFF_TIMING2, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, OFF_TIMING1, {8'h00, 2'(k), (k == 3) ? 6'h3f : 6'(k)});
      @(negedge core_clk_in) check(jw, k + 1, "jump width");
      span(0, 0, n);
      check(n, (k == 3) ? 128 : 2 * (k + 1), "quantum");
    end
    bus(1'b1, OFF_TIMING1, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, OFF_TIMING2, T2V[i]);
      span(1, 1, n);
      check(n, T2C[i], "bit time");
    end
    span(1, 2, n);
    check(n, 6, "sample point");
    $display("test timing done");
    bus(1'b1, OFF_TIMING2, 16'h4000);
    pulse(8'h00, 16'h0, 8'h02);
    repeat (10) @(posedge core_clk_in);
    rd(OFF_FLAGS, 32'h0000);
    bus(1'b1, OFF_TIMING2, 16'h0000);
    pulse(8'h00, 16'h0, 8'h01);
    repeat (10) @(posedge core_clk_in);
    rd(OFF_FLAGS, 32'h0040);
    bus(1'b1, OFF_FLAGS, 16'h0000);
    bus(1'b1, OFF_TIMING2, 16'h4040);
    pulse(8'h00, 16'h0, 8'd60);
    repeat (50) @(posedge core_clk_in);
    @(negedge core_clk_in) check(sb, 1'b0, "sampled bit");
    repeat (20) @(posedge core_clk_in);
    rd(OFF_FLAGS, 32'h0040);
    $display("test wake done");
    bus(1'b1, OFF_FILT_EN, 16'hffff);
    bus(1'b1, 6'h18, 16'hcdef);
    bus(1'b1, 6'h1c, 16'h89ab);
    bus(1'b1, 6'h20, 16'h4567);
    bus(1'b1, 6'h24, 16'h0123);
    for (int f = 0; f < 16; f++) begin
      h = 16'(rnd()) & (16'hffff << f);
      h[f] = 1'b1;
      acc_q.push_back({4'(f), f == 0, 4'(15 - f)});
      pulse(8'h00, h, 8'h00);
    end
    bus(1'b1, OFF_FILT_EN, 16'hfffe);
    pulse(8'h00, 16'h0001, 8'h00);
    acc_q.push_back({4'h1, 1'b0, 4'he});
    pulse(8'h00, 16'h0003, 8'h00);
    repeat (4) @(posedge core_clk_in);
    check(acc_q.size(), 0, "accept count");
    check(rd_q.size(), 0, "read count");
    $display("test filters done");
    test_done();
  end
endmodule
